// ==== ppa_page_port.sv ====
`timescale 1ns/1ps
`include "ppa_consts.svh"

module ppa_page_port
(
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       reset,
  input  wire logic                       clk_en,
  // Avalon-MM slave
  input  wire logic [`PPA_ADDR_W-1:0]     avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic [31:0]                     avs_readdata,
  output logic                            avs_waitrequest,
  output logic [1:0]                      avs_response,
  // Page port pins
  input  wire logic [7:0]                 page_pin_in,
  output logic [7:0]                      page_pin_out,
  output logic [7:0]                      page_pin_oe,
  output logic [7:0]                      page_pull_up,
  // Core external access request
  input  wire ppa_pkg::ppa_req_t          ext_req,
  // Echo of page register accesses to the external bus
  output logic                            echo_valid,
  output logic                            echo_write,
  output logic [7:0]                      echo_index,
  output logic [7:0]                      echo_wdata,
  // Bus control outputs
  output ppa_pkg::ppa_busctl_t            busctl,
  output logic                            bus_e_clock
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]  page_port_data;
  logic [7:0]  page_port_direction;
  logic [4:0]  ctrl;
  logic [7:0]  pin_meta;
  logic [7:0]  pin_sync;
  logic        ack;
  logic        page_emulation_enable;
  logic        page_pull_enable;
  logic        e_stretch_enable;
  logic        mapped_out;
  logic        req_active;
  logic        hit_data;
  logic        hit_dir;
  logic        hit_ctrl;
  logic        hit_status;
  logic        hit_any;
  logic        wr_lo;
  logic [31:0] next_readdata;

  assign page_emulation_enable = ctrl[`PPA_CTRL_EMK];
  assign page_pull_enable      = ctrl[`PPA_CTRL_PULL];
  assign e_stretch_enable      = ctrl[`PPA_CTRL_E_STRETCH_ENABLE];

  // Page registers leave the internal map
  assign mapped_out = ctrl[`PPA_CTRL_PERIPH] ||
                      (ctrl[`PPA_CTRL_EXPAND] && page_emulation_enable);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign req_active = avs_read || avs_write;
  assign hit_data   = avs_address == `PPA_ADDR_DATA;
  assign hit_dir    = avs_address == `PPA_ADDR_DIR;
  assign hit_ctrl   = avs_address == `PPA_ADDR_CTRL;
  assign hit_status = avs_address == `PPA_ADDR_STATUS;
  assign hit_any    = hit_data || hit_dir || hit_ctrl || hit_status;
  assign wr_lo      = avs_write && avs_byteenable[0] && ack && clk_en;

  // One wait cycle then acknowledge; a write lands on the edge that
  // accepts it, with waitrequest low
  assign avs_waitrequest = req_active && !(ack && clk_en);

  always_ff @(posedge core_clk)
  begin
    if (reset)
      ack <= 1'b0;
    else if (clk_en)
      ack <= req_active && !ack;
  end

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
    end
    else if (clk_en)
    begin
      pin_meta <= page_pin_in;
      pin_sync <= pin_meta;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (reset)
      page_port_data <= `PPA_DATA_RST;
    else if (wr_lo && hit_data && !mapped_out)
      page_port_data <= avs_writedata[7:0];
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      page_port_direction <= `PPA_DIR_RST;
    else if (wr_lo && hit_dir && !mapped_out)
      page_port_direction <= avs_writedata[7:0];
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      ctrl <= `PPA_CTRL_RST;
    else if (wr_lo && hit_ctrl)
      ctrl <= avs_writedata[4:0];
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb
  begin
    next_readdata = 32'h0000_0000;
    if (hit_data && !mapped_out)
      // Pin for inputs, latch for outputs
      next_readdata[7:0] = (pin_sync & ~page_port_direction) |
                           (page_port_data & page_port_direction);
    else if (hit_dir && !mapped_out)
      next_readdata[7:0] = page_port_direction;
    else if (hit_ctrl)
      next_readdata[4:0] = ctrl;
    else if (hit_status)
      next_readdata[8:0] = {bus_e_clock, page_pin_out};
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'b00;
    end
    else if (clk_en && req_active && !ack)
    begin
      avs_readdata <= next_readdata;
      avs_response <= hit_any ? 2'b00 : 2'b11;
    end
  end

  // Echo data and direction register accesses externally when unmapped
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      echo_valid <= 1'b0;
      echo_write <= 1'b0;
      echo_index <= 8'h00;
      echo_wdata <= 8'h00;
    end
    else if (clk_en)
    begin
      echo_valid <= req_active && !ack && mapped_out && (hit_data || hit_dir);
      echo_write <= avs_write;
      echo_index <= hit_data ? `PPA_IDX_DATA : `PPA_IDX_DIR;
      echo_wdata <= avs_writedata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // E clock
  // ----------------------------------------------------------------
  ppa_pkg::ppa_estate_t e_state;
  logic [1:0]           e_cnt;
  logic                 cs_blank;
  logic                 stretched;

  assign stretched = ext_req.valid && ext_req.stretch;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      e_state <= ppa_pkg::PPA_E_LOW;
      e_cnt   <= 2'h0;
    end
    else if (clk_en)
    begin
      case (e_state)
        ppa_pkg::PPA_E_LOW:
          if (e_cnt == 2'(`PPA_E_HALF - 1))
          begin
            e_state <= ppa_pkg::PPA_E_HIGH;
            e_cnt   <= 2'h0;
          end
          else
            e_cnt <= e_cnt + 2'h1;
        ppa_pkg::PPA_E_HIGH:
          if (e_cnt == 2'(`PPA_E_HALF - 1))
          begin
            // Hold E high through a stretch only when enabled
            e_state <= (stretched && e_stretch_enable) ?
                       ppa_pkg::PPA_E_STRETCH : ppa_pkg::PPA_E_LOW;
            e_cnt   <= 2'h0;
          end
          else
            e_cnt <= e_cnt + 2'h1;
        ppa_pkg::PPA_E_STRETCH:
          if (!stretched || !e_stretch_enable)
            e_state <= ppa_pkg::PPA_E_LOW;
        default:
          e_state <= ppa_pkg::PPA_E_LOW;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      bus_e_clock <= 1'b0;
    else if (clk_en)
      bus_e_clock <= e_state != ppa_pkg::PPA_E_LOW;
  end

  // Selects released briefly after E falls, except stretched free-run;
  // decoded from the state so the pins rise on the edge where E falls
  assign cs_blank = bus_e_clock && (e_state == ppa_pkg::PPA_E_LOW) &&
                    !(stretched && !e_stretch_enable);

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  logic [7:0] next_pin_out;
  logic [7:0] next_pin_oe;

  always_comb
  begin
    next_pin_out = page_port_data;
    next_pin_oe  = page_port_direction;
    if (page_emulation_enable)
    begin
      next_pin_oe = 8'hff;
      next_pin_out[`PPA_BIT_ECS] = !(ext_req.valid && ext_req.emul_sel)
                                   || cs_blank;
      next_pin_out[`PPA_BIT_XCS] = !(ext_req.valid && !ext_req.emul_sel
                                     && !ext_req.ram_target)
                                   || cs_blank;
      next_pin_out[5:0] = ext_req.page;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      page_pin_out <= 8'h00;
      page_pin_oe  <= 8'h00;
    end
    else if (clk_en)
    begin
      page_pin_out <= next_pin_out;
      page_pin_oe  <= next_pin_oe;
    end
  end

  // Pull-ups only on pins acting as inputs
  assign page_pull_up = {8{page_pull_enable}} & ~page_pin_oe;

  ppa_bus_encoder u_encoder
  (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .req      (ext_req),
    .busctl   (busctl)
  );

endmodule // ppa_page_port

// ==== ppa_consts.svh ====
`ifndef PPA_CONSTS_SVH
`define PPA_CONSTS_SVH

// Register byte addresses (index times four, printed offsets not aligned)
`define PPA_IDX_DATA      8'h32
`define PPA_IDX_DIR       8'h33
`define PPA_IDX_CTRL      8'h34
`define PPA_IDX_STATUS    8'h35
`define PPA_ADDR_W        10
`define PPA_ADDR_DATA     10'h0c8
`define PPA_ADDR_DIR      10'h0cc
`define PPA_ADDR_CTRL     10'h0d0
`define PPA_ADDR_STATUS   10'h0d4

// Control register fields
`define PPA_CTRL_PULL     0
`define PPA_CTRL_E_STRETCH_ENABLE     1
`define PPA_CTRL_EMK      2
`define PPA_CTRL_PERIPH   3
`define PPA_CTRL_EXPAND   4

// Reset values
`define PPA_DIR_RST       8'h00
`define PPA_DATA_RST      8'h00
`define PPA_CTRL_RST      5'h02

// Page port bit positions
`define PPA_BIT_ECS       7
`define PPA_BIT_XCS       6
`define PPA_PAGE_W        6

// E clock timing: one E period is four core clocks, blank is 1/4 of it
`define PPA_E_PERIOD      4
`define PPA_E_HALF        2
`define PPA_CS_BLANK      1

`endif

// ==== ppa_pkg.sv ====
package ppa_pkg;

  // External access request from the core
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        word;
    logic        addr0;
    logic        ram_target;
    logic        emul_sel;
    logic        stretch;
    logic [5:0]  page;
    logic [15:0] wdata;
  } ppa_req_t;

  // Bus control outputs
  typedef struct packed {
    logic        low_byte_strobe_n;
    logic        address_bit_zero;
    logic        read_not_write;
    logic [15:0] data;
  } ppa_busctl_t;

  typedef enum logic [1:0] {
    PPA_E_LOW     = 2'b00,
    PPA_E_HIGH    = 2'b01,
    PPA_E_STRETCH = 2'b11
  } ppa_estate_t;

endpackage

// ==== ppa_bus_encoder.sv ====
`timescale 1ns/1ps
`include "ppa_consts.svh"

module ppa_bus_encoder
(
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  input  wire logic                 clk_en,
  // Request
  input  wire ppa_pkg::ppa_req_t    req,
  // Encoded bus control
  output ppa_pkg::ppa_busctl_t      busctl
);

  ppa_pkg::ppa_busctl_t next_busctl;
  logic                 swap;

  always_comb
  begin
    swap = req.word && req.addr0;
    next_busctl.read_not_write = !req.write;
    if (req.word)
    begin
      // Word: aligned strobe low, odd RAM strobe high, odd non-RAM strobe low
      next_busctl.low_byte_strobe_n = req.addr0 && req.ram_target;
      next_busctl.address_bit_zero  = req.addr0 && req.ram_target;
    end
    else
    begin
      // Byte: even 1,0 and odd 0,1
      next_busctl.low_byte_strobe_n = !req.addr0;
      next_busctl.address_bit_zero  = req.addr0;
    end
    // Addressed byte on low half, next byte on high half, except odd RAM words, which keep wdata as is
    if (swap && req.ram_target)
      next_busctl.data = req.wdata;
    else
      next_busctl.data = {req.wdata[7:0], req.wdata[15:8]};
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      busctl <= '{low_byte_strobe_n: 1'b1, address_bit_zero: 1'b0,
                  read_not_write: 1'b1, data: 16'h0000};
    else if (clk_en && req.valid)
      busctl <= next_busctl;
  end

endmodule // ppa_bus_encoder

// ==== ppa_page_port_checker.sv ====
`timescale 1ns/1ps
`include "ppa_consts.svh"

module ppa_page_port_checker
(
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              reset,
  input wire logic              clk_en,
  // Register bus
  input wire logic [9:0]        avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_writedata,
  input wire logic              avs_waitrequest,
  // Pins and bus control
  input wire logic [7:0]        page_pin_out,
  input wire logic [7:0]        page_pin_oe,
  input wire logic [7:0]        page_pull_up,
  input wire ppa_pkg::ppa_req_t ext_req,
  input wire logic              echo_valid,
  input wire logic              echo_write,
  input wire logic [7:0]        echo_index,
  input wire logic [7:0]        echo_wdata,
  input wire ppa_pkg::ppa_busctl_t busctl,
  input wire logic              bus_e_clock
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  logic [4:0] ctrl;
  wire req = avs_read || avs_write;
  wire hit = req && !avs_waitrequest;
  wire gone = ctrl[3] || (ctrl[4] && ctrl[2]);
  wire sw = ext_req.addr0 && ext_req.ram_target;
  wire str_free = ext_req.valid && ext_req.stretch && !ctrl[1];
  // --------------------------------
  // Control mirror
  // --------------------------------
  always_ff @(posedge core_clk)
    if (reset)
      ctrl <= `PPA_CTRL_RST;
    else if (avs_write && hit && avs_address == `PPA_ADDR_CTRL)
      ctrl <= avs_writedata[4:0];
  sequence s_byte;
    clk_en && ext_req.valid && !ext_req.word;
  endsequence
  sequence s_word;
    clk_en && ext_req.valid && ext_req.word;
  endsequence
  property p_byte;
    s_byte |=> busctl.address_bit_zero == $past(ext_req.addr0)
      && busctl.low_byte_strobe_n == !$past(ext_req.addr0)
      && busctl.read_not_write == !$past(ext_req.write);
  endproperty
  property p_one;
    s_byte |=> !(busctl.low_byte_strobe_n && busctl.address_bit_zero);
  endproperty
  property p_word;
    s_word |=> busctl.address_bit_zero == $past(sw)
      && busctl.low_byte_strobe_n == $past(sw)
      && busctl.read_not_write == !$past(ext_req.write);
  endproperty
  property p_swap;
    s_word ##0 (sw && ext_req.write) |=> busctl.data == $past(ext_req.wdata);
  endproperty
  property p_pull;
    page_pull_up == (ctrl[0] ? ~page_pin_oe : 8'h00);
  endproperty
  property p_rst;
    $fell(reset) |-> page_pin_oe == 8'h00;
  endproperty
  property p_echo;
    hit && gone && avs_address inside {`PPA_ADDR_DATA, `PPA_ADDR_DIR}
      |-> ##[0:2] echo_valid;
  endproperty
  property p_elow;
    $fell(bus_e_clock) |=> !bus_e_clock ##1 bus_e_clock;
  endproperty
  property p_ack;
    $rose(req) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  property p_ecs;
    $fell(bus_e_clock) && $past(ctrl[2]) |-> page_pin_out[7] ==
      (!$past(ext_req.valid && ext_req.emul_sel) || !$past(str_free));
  endproperty
  property p_xcs;
    $fell(bus_e_clock) && $past(ctrl[2]) |-> page_pin_out[6] ==
      (!$past(ext_req.valid && !ext_req.emul_sel && !ext_req.ram_target)
       || !$past(str_free));
  endproperty
  property p_hold;
    bus_e_clock && $past(ext_req.valid && ext_req.stretch && ctrl[1])
      |=> bus_e_clock;
  endproperty
  property p_etag;
    echo_valid |-> echo_write == avs_write
      && echo_wdata == avs_writedata[7:0]
      && echo_index == ((avs_address == `PPA_ADDR_DATA) ?
                        `PPA_IDX_DATA : `PPA_IDX_DIR);
  endproperty
  a_byte: assert property (p_byte)
    else $error("byte access code wrong");
  a_one: assert property (p_one)
    else $error("strobe and bit zero high on byte access");
  a_word: assert property (p_word)
    else $error("word access code wrong");
  a_swap: assert property (p_swap)
    else $error("swapped word data misplaced");
  a_pull: assert property (p_pull)
    else $error("pull-up mismatch");
  a_rst: assert property (p_rst)
    else $error("pins driven after reset");
  a_echo: assert property (p_echo)
    else $error("mapped-out access not echoed");
  a_elow: assert property (p_elow)
    else $error("E low phase wrong");
  a_ack: assert property (p_ack)
    else $error("bus answer late");
  a_ecs: assert property (p_ecs)
    else $error("emulation select wrong after E fall");
  a_xcs: assert property (p_xcs)
    else $error("external select wrong after E fall");
  a_hold: assert property (p_hold)
    else $error("E fell during stretched access");
  a_etag: assert property (p_etag)
    else $error("echoed access fields wrong");
endmodule // ppa_page_port_checker

bind ppa_page_port ppa_page_port_checker chk_u
(
  .core_clk, .reset, .clk_en, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_waitrequest, .page_pin_out, .page_pin_oe,
  .page_pull_up, .ext_req, .echo_valid, .echo_write, .echo_index,
  .echo_wdata, .busctl, .bus_e_clock
);

// ==== ppa_ext_dev.sv ====
`timescale 1ns/1ps

module ppa_ext_dev
(
  // Clock
  input wire logic       core_clk,
  // Port pins
  input wire logic [7:0] page_pin_out,
  input wire logic [7:0] page_pin_oe,
  input wire logic [7:0] page_pull_up,
  output logic [7:0]     page_pin_in,
  // Far device drive
  input wire logic [7:0] page_drv,
  input wire logic [7:0] page_drv_en
);
  logic [7:0] churn = 8'h5a;
  always @(posedge core_clk)
    churn <= ~churn;
  // Undriven bits pull high or keep changing
  assign page_pin_in = (page_pin_oe & page_pin_out)
    | (~page_pin_oe & page_drv_en & page_drv)
    | (~page_pin_oe & ~page_drv_en & (page_pull_up | churn));
endmodule // ppa_ext_dev

// ==== ppa_page_port_bench.sv ====
`timescale 1ns/1ps
`include "ppa_consts.svh"

module ppa_page_port_bench;
  logic                 core_clk = 1'b0;
  logic                 reset = 1'b1;
  logic [9:0]           avs_address = '0;
  logic                 avs_read = 1'b0;
  logic                 avs_write = 1'b0;
  logic [31:0]          avs_writedata = '0;
  logic [31:0]          avs_readdata, q;
  logic                 avs_waitrequest, echo_valid, bus_e_clock;
  logic [1:0]           avs_response, rsp;
  logic [7:0]           page_pin_in, page_pin_out, page_pin_oe;
  logic [7:0]           page_pull_up, dat, dir;
  logic [7:0]           page_drv = '0;
  logic [7:0]           page_drv_en = '0;
  ppa_pkg::ppa_req_t    ext_req = '0;
  ppa_pkg::ppa_req_t    r;
  ppa_pkg::ppa_busctl_t busctl;
  int                   n_errors = 0;
  int                   n_tests = 0;
  int                   ne, nc;

  always #12.5 core_clk = ~core_clk;

  ppa_page_port dut_u
  (
    .core_clk, .reset, .clk_en(1'b1), .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata,
    .avs_waitrequest, .avs_response, .page_pin_in, .page_pin_out,
    .page_pin_oe, .page_pull_up, .ext_req, .echo_valid, .echo_write(),
    .echo_index(), .echo_wdata(), .busctl, .bus_e_clock
  );

  ppa_ext_dev far_u
  (
    .core_clk, .page_pin_out, .page_pin_oe, .page_pull_up,
    .page_pin_in, .page_drv, .page_drv_en
  );

  // --------------------------------
  // Tasks
  // --------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [9:0] a,
                     input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge core_clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    rsp = avs_response;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic results();
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic logic [2:0] enc(input logic w, wd, a0, ram);
    logic s;
    s = wd ? (a0 & ram) : !a0;
    return {s, wd ? (a0 & ram) : a0, !w};
  endfunction

  // --------------------------------
  // Tests
  // --------------------------------
  initial
  begin
    #(25 * 20000);
    n_errors++;
    results();
  end

  initial
  begin
    q = $urandom(32'hda5b6afd);
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    bus(1'b0, `PPA_ADDR_DIR, '0);
    chk(q, 32'h0);
    bus(1'b0, `PPA_ADDR_CTRL, '0);
    chk(q, 32'h2);
    bus(1'b0, 10'h3fc, '0);
    chk({30'h0, rsp}, 32'h3);
    page_drv_en <= 8'hff;
    for (int i = 0; i < 5; i++)
    begin
      dat = 8'($urandom);
      dir = (i < 2) ? {8{i[0]}} : 8'($urandom);
      page_drv <= 8'($urandom);
      bus(1'b1, `PPA_ADDR_DATA, {24'h0, dat});
      bus(1'b1, `PPA_ADDR_DIR, {24'h0, dir});
      repeat (3) @(posedge core_clk);
      bus(1'b0, `PPA_ADDR_DATA, '0);
      chk(q, {24'h0, (dir & dat) | (~dir & page_drv)});
      chk({24'h0, page_pin_oe}, {24'h0, dir});
    end
    page_drv_en <= 8'h00;
    bus(1'b1, `PPA_ADDR_CTRL, 32'h3);
    chk({24'h0, page_pull_up}, {24'h0, ~dir});
    for (int i = 0; i < 16; i++)
    begin
      r = '0;
      r.valid = 1'b1;
      r.write = i[0];
      r.word = i[1];
      r.addr0 = i[2];
      r.ram_target = i[3];
      r.wdata = 16'($urandom);
      ext_req <= r;
      @(posedge core_clk);
      ext_req.valid <= 1'b0;
      @(posedge core_clk);
      chk({29'h0, busctl[18:16]}, {29'h0, enc(i[0], i[1], i[2], i[3])});
      if (i == 15)
        chk({16'h0, busctl.data}, {16'h0, r.wdata});
      else if (!(i[1] && i[2] && i[3]))
        chk({16'h0, busctl.data},
            {16'h0, r.wdata[7:0], r.wdata[15:8]});
    end
    bus(1'b1, `PPA_ADDR_CTRL, 32'h16);
    bus(1'b1, `PPA_ADDR_DATA, 32'h5a);
    bus(1'b1, `PPA_ADDR_DIR, {24'h0, ~dir});
    r = '0;
    r.valid = 1'b1;
    r.emul_sel = 1'b1;
    r.page = 6'($urandom);
    ext_req <= r;
    @(posedge core_clk);
    ext_req.valid <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk({26'h0, page_pin_out[5:0]}, {26'h0, r.page});
    // Held accesses: free-running, stretched, then stretch disabled
    for (int k = 0; k < 3; k++)
    begin
      if (k == 2)
      begin
        ext_req.valid <= 1'b0;
        @(posedge core_clk);
        bus(1'b1, `PPA_ADDR_CTRL, 32'h14);
      end
      r.valid = 1'b1;
      r.emul_sel = (k != 0);
      r.stretch = (k != 0);
      ext_req <= r;
      repeat (4) @(posedge core_clk);
      ne = 0;
      nc = 0;
      repeat (8)
      begin
        @(posedge core_clk);
        ne += bus_e_clock;
        nc += page_pin_out[k == 0 ? 6 : 7];
      end
      chk(ne, k == 1 ? 8 : 4);
      chk(nc, k == 0 ? 2 : 0);
    end
    ext_req.valid <= 1'b0;
    bus(1'b1, `PPA_ADDR_CTRL, 32'h0);
    bus(1'b0, `PPA_ADDR_DIR, '0);
    chk(q, {24'h0, dir});
    results();
  end
endmodule // ppa_page_port_bench
